// ===== design/sac_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl import sac_pkg::*; #(
	parameter int RES_BITS = 12
) (
	// System
	input wire logic clk,
	input wire logic reset,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	// Conversion clock pin
	input wire logic oscillator_enable_pin,
	input wire logic conversion_clock_in,
	output logic conversion_clock_out,
	output logic conversion_clock_oe,
	output logic conv_clk_int,
	// Converter core
	input wire logic conv_valid,
	input wire logic [RES_BITS-1:0] conv_result,
	output logic conv_start,
	output logic [2:0] analog_input_select,
	output logic input_polarity_select,
	output logic [2:0] gain_select_bits,
	output logic ref_enable,
	output logic reference_buffer_enable
);
	// Link-domain state
	sac_link_state_e state, next_state;
	logic [4:0] cnt, next_cnt;
	logic [6:0] cmd, next_cmd;
	logic [15:0] sh, next_sh;
	logic next_dout, next_dout_oe;
	logic wide, next_wide;
	logic [4:0] addr, next_addr;
	logic [6:0] gain_mux, next_gain_mux;
	logic [1:0] ref_ctl, next_ref_ctl;
	logic cfg_tgl, next_cfg_tgl, conv_tgl, next_conv_tgl;
	logic [RES_BITS-1:0] res_mirror, next_res_mirror;
	logic res_seen, next_res_seen;
	logic res_s;
	logic frame_clr;
	// System-domain state
	logic link_reset;
	logic [OSC_CNT_W-1:0] osc_cnt, next_osc_cnt;
	logic next_osc_out, next_clk_oe, next_clk_int, next_conv_start;
	logic [1:0] pin_s, tgl_s;
	logic seen_cfg, next_seen_cfg, seen_conv, next_seen_conv;
	logic [2:0] next_chan, next_gain;
	logic next_pol, next_ref_on, next_buf_en;
	logic [RES_BITS-1:0] result, next_result;
	logic res_tgl, next_res_tgl;

	assign frame_clr = cs_n | link_reset;

	sac_sync #(.WIDTH(2)) u_pin_sync (
		.clk(clk),
		.clear(1'b0),
		.d({oscillator_enable_pin, conversion_clock_in}),
		.q(pin_s)
	);
	sac_sync #(.WIDTH(2)) u_tgl_sync (
		.clk(clk),
		.clear(1'b0),
		.d({conv_tgl, cfg_tgl}),
		.q(tgl_s)
	);
	sac_sync #(.WIDTH(1)) u_res_sync (
		.clk(sclk),
		.clear(link_reset),
		.d(res_tgl),
		.q(res_s)
	);

	function automatic logic [7:0] reg_rd(input logic [4:0] a, input logic [RES_BITS-1:0] r,
			input logic [6:0] gm, input logic [1:0] rc);
		logic [15:0] rw;
		rw = {r, RESULT_PAD'(0)};
		case (a)
			ADDR_RES_LO: reg_rd = rw[7:0]; // see (R13)
			ADDR_RES_HI: reg_rd = rw[15:8]; // see (R13)
			ADDR_GAIN_MUX: reg_rd = {1'b0, gm};
			ADDR_REF: reg_rd = {6'h00, rc};
			default: reg_rd = 8'h00;
		endcase
	endfunction

	// Serial frame engine, rising edge only
	always_comb begin
		logic [7:0] cb;
		logic [15:0] word;
		logic [15:0] wd;
		logic [4:0] last;
		logic [4:0] a_hi;
		cb = {cmd, din};
		word = 16'h0000;
		wd = {sh[14:0], din};
		last = wide ? DATA16_LAST : DATA8_LAST;
		a_hi = 5'(addr + 5'h01);
		next_state = state;
		next_cnt = (cnt == 5'h1f) ? cnt : 5'(cnt + 5'h01); // see (R16)
		next_cmd = cmd;
		next_sh = sh;
		next_dout = dout;
		next_dout_oe = dout_oe;
		next_wide = wide;
		next_addr = addr;
		next_gain_mux = gain_mux;
		next_ref_ctl = ref_ctl;
		next_cfg_tgl = cfg_tgl;
		next_conv_tgl = conv_tgl;
		next_res_seen = res_s;
		next_res_mirror = (res_s != res_seen) ? result : res_mirror;
		unique case (state)
			ST_CMD: begin
				next_cmd = {cmd[5:0], din};
				if (cnt == CMD_LAST) begin
					if (cb[CMD_DIRECT_BIT]) begin
						next_gain_mux = cb[6:0]; // see (R15)
						next_conv_tgl = ~conv_tgl;
						next_wide = 1'b1;
						word = {res_mirror, RESULT_PAD'(0)}; // see (R10)
						next_state = ST_RDATA;
					end else begin
						next_addr = cb[4:0]; // see (R14)
						next_wide = cb[CMD_WIDE_BIT];
						if (cb[CMD_READ_BIT]) begin
							if (cb[CMD_WIDE_BIT]) begin
								word = {reg_rd(5'(cb[4:0] + 5'h01), res_mirror, gain_mux, ref_ctl),
									reg_rd(cb[4:0], res_mirror, gain_mux, ref_ctl)};
							end else begin
								word = {reg_rd(cb[4:0], res_mirror, gain_mux, ref_ctl), 8'h00};
							end
							next_state = ST_RDATA;
						end else begin
							next_state = ST_WDATA;
						end
					end
					if (next_state == ST_RDATA) begin
						next_dout = word[15];
						next_sh = {word[14:0], 1'b0};
						next_dout_oe = 1'b1;
					end
				end
			end
			ST_WDATA: begin
				next_sh = wd;
				if (cnt == last) begin
					if (wide) begin
						if (a_hi == ADDR_GAIN_MUX) next_gain_mux = wd[14:8];
						if (a_hi == ADDR_REF) next_ref_ctl = wd[9:8];
					end
					if (addr == ADDR_GAIN_MUX) next_gain_mux = wd[6:0]; // see (R1) (R7)
					if (addr == ADDR_REF) next_ref_ctl = wd[1:0]; // see (R5) (R6)
					next_cfg_tgl = ~cfg_tgl;
					next_state = ST_DONE;
				end
			end
			ST_RDATA: begin
				next_dout = sh[15];
				next_sh = {sh[14:0], 1'b0};
				if (cnt == last) begin
					next_dout_oe = 1'b0;
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_dout_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sclk or posedge frame_clr) begin // see (R9) (R8)
		if (frame_clr) begin
			state <= ST_CMD; // see (R16)
			cnt <= 5'h00;
			cmd <= 7'h00;
			sh <= 16'h0000;
			dout <= 1'b0;
			dout_oe <= 1'b0;
			wide <= 1'b0;
			addr <= 5'h00;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			cmd <= next_cmd;
			sh <= next_sh;
			dout <= next_dout;
			dout_oe <= next_dout_oe;
			wide <= next_wide;
			addr <= next_addr;
		end
	end

	always_ff @(posedge sclk or posedge link_reset) begin
		if (link_reset) begin
			gain_mux <= GAIN_MUX_RST;
			ref_ctl <= REF_CTL_RST;
			cfg_tgl <= 1'b0;
			conv_tgl <= 1'b0;
			res_mirror <= '0;
			res_seen <= 1'b0;
		end else begin
			gain_mux <= next_gain_mux;
			ref_ctl <= next_ref_ctl;
			cfg_tgl <= next_cfg_tgl;
			conv_tgl <= next_conv_tgl;
			res_mirror <= next_res_mirror;
			res_seen <= next_res_seen;
		end
	end

	// System side: oscillator, settings, conversion start, result
	always_comb begin
		logic upd;
		upd = (tgl_s[0] != seen_cfg) || (tgl_s[1] != seen_conv);
		next_osc_cnt = 7'(osc_cnt + 7'h01);
		next_osc_out = conversion_clock_out;
		if (osc_cnt == 7'(OSC_HALF_CYCLES - 1)) begin
			next_osc_cnt = '0;
			next_osc_out = ~conversion_clock_out;
		end
		next_clk_oe = pin_s[1]; // see (R3)
		next_clk_int = pin_s[1] ? conversion_clock_out : pin_s[0]; // see (R3)
		next_seen_cfg = tgl_s[0];
		next_seen_conv = tgl_s[1];
		next_conv_start = tgl_s[1] != seen_conv; // see (R15)
		next_chan = analog_input_select;
		next_pol = input_polarity_select;
		next_gain = gain_select_bits;
		next_ref_on = ref_enable;
		next_buf_en = reference_buffer_enable;
		if (upd) begin
			next_chan = gain_mux[GM_CHAN_LSB+:3]; // see (R1)
			next_pol = gain_mux[GM_POL_BIT]; // see (R2)
			next_gain = gain_mux[GM_GAIN_LSB+:3]; // see (R7)
			next_ref_on = ref_ctl[REF_ON_BIT]; // see (R5)
			next_buf_en = ref_ctl[REF_BUF_BIT]; // see (R6)
		end
		next_result = conv_valid ? conv_result : result; // see (R13)
		next_res_tgl = conv_valid ? ~res_tgl : res_tgl;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			link_reset <= 1'b1;
			osc_cnt <= '0;
			conversion_clock_out <= 1'b0;
			conversion_clock_oe <= 1'b0;
			conv_clk_int <= 1'b0;
			seen_cfg <= 1'b0;
			seen_conv <= 1'b0;
			conv_start <= 1'b0;
			analog_input_select <= GAIN_MUX_RST[GM_CHAN_LSB+:3];
			input_polarity_select <= GAIN_MUX_RST[GM_POL_BIT];
			gain_select_bits <= GAIN_MUX_RST[GM_GAIN_LSB+:3];
			ref_enable <= REF_CTL_RST[REF_ON_BIT];
			reference_buffer_enable <= REF_CTL_RST[REF_BUF_BIT];
			result <= '0;
			res_tgl <= 1'b0;
		end else begin
			link_reset <= 1'b0;
			osc_cnt <= next_osc_cnt;
			conversion_clock_out <= next_osc_out;
			conversion_clock_oe <= next_clk_oe;
			conv_clk_int <= next_clk_int;
			seen_cfg <= next_seen_cfg;
			seen_conv <= next_seen_conv;
			conv_start <= next_conv_start;
			analog_input_select <= next_chan;
			input_polarity_select <= next_pol;
			gain_select_bits <= next_gain;
			ref_enable <= next_ref_on;
			reference_buffer_enable <= next_buf_en;
			result <= next_result;
			res_tgl <= next_res_tgl;
		end
	end

	// Checks
	property p_start_pulse;
		@(posedge clk) disable iff (reset) conv_start |=> !conv_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle"); // see (R15)
	property p_clk_dir;
		@(posedge clk) disable iff (reset) 1'b1 |=> conversion_clock_oe == $past(pin_s[1]);
	endproperty
	a_clk_dir: assert property (p_clk_dir) else $error("clock direction wrong"); // see (R3)
	property p_osc_flip;
		@(posedge clk) disable iff (reset)
			osc_cnt == 7'(OSC_HALF_CYCLES - 1) |=> conversion_clock_out != $past(conversion_clock_out);
	endproperty
	a_osc_flip: assert property (p_osc_flip) else $error("oscillator half period wrong"); // see (R3)
	property p_gain_only_on_update;
		@(posedge clk) disable iff (reset)
			$changed(gain_select_bits) |-> $past(tgl_s) != $past({seen_conv, seen_cfg});
	endproperty
	a_gain_only_on_update: assert property (p_gain_only_on_update) else $error("gain moved"); // see (R7)
	property p_ref_follows;
		@(posedge clk) disable iff (reset)
			(tgl_s[0] != seen_cfg) ##1 $stable(ref_ctl) |-> ref_enable == ref_ctl[REF_ON_BIT];
	endproperty
	a_ref_follows: assert property (p_ref_follows) else $error("reference not applied"); // see (R5)
	property p_result_hold;
		@(posedge clk) disable iff (reset) !conv_valid |=> $stable(result);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result changed"); // see (R13)
	property p_oe_read_only;
		@(posedge sclk) disable iff (frame_clr) dout_oe |-> state == ST_RDATA;
	endproperty
	a_oe_read_only: assert property (p_oe_read_only) else $error("data out driven"); // see (R16)
	property p_direct_readback;
		@(posedge sclk) disable iff (frame_clr)
			state == ST_CMD && cnt == CMD_LAST && cmd[6] |=> dout_oe && dout == $past(res_mirror[RES_BITS-1]);
	endproperty
	a_direct_readback: assert property (p_direct_readback) else $error("no readback"); // see (R15)
	property p_write_commits;
		@(posedge sclk) disable iff (frame_clr)
			state == ST_WDATA && cnt == (wide ? DATA16_LAST : DATA8_LAST) |=> $changed(cfg_tgl);
	endproperty
	a_write_commits: assert property (p_write_commits) else $error("write lost"); // see (R14)
	c_direct: cover property (@(posedge sclk) disable iff (frame_clr) state == ST_RDATA && cnt == DATA16_LAST);
	c_write: cover property (@(posedge sclk) disable iff (frame_clr) state == ST_WDATA ##1 state == ST_DONE);
	c_start: cover property (@(posedge clk) disable iff (reset) conv_start);
endmodule // sac_adc_ctrl
`default_nettype wire

// ===== design/sac_pkg.sv
// How it works
// (R1) Four-bit mux field in register 4 selects one of eight analogue inputs.
// (R2) Polarity bit of the mux field picks single-ended or differential polarity.
// (R3) Oscillator pin high: drive 2.5 MHz conversion clock; low: accept external clock.
// (R4) Controller runs its logic from the conversion clock output; this code runs from clk and sclk instead.
// (R5) Register 7 switches the internal voltage reference on or off.
// (R6) Buffer enable bit in register 7 selects internal or external reference.
// (R7) Three gain bits in register 4 pick gain 1,2,4,5,8,10,16,20.
// (R8) All traffic uses serial clock, data in, data out and chip select.
// (R9) Serial data is taken on the rising serial clock edge.
// (R10) A 12-bit result for the selected channel goes out through the port.
// (R11) Controller stores each result as one 16-bit memory word; this code keeps only the latest 12-bit result in a register.
// (R12) Controller takes settings, counts and addresses from build-time constants; this code takes settings from registers 4 and 7, set over the serial link.
// (R13) Result is two's complement, held in registers 0 and 1.
// (R14) Register mode: command byte with address, read/write, width; data follows.
// (R15) Direct command starts a conversion; result shifts out from the next edge.
// (R16) Chip select high floats data out and restarts the edge counter.
package sac_pkg;
	// Register map
	localparam logic [4:0] ADDR_RES_LO = 5'h00;
	localparam logic [4:0] ADDR_RES_HI = 5'h01;
	localparam logic [4:0] ADDR_GAIN_MUX = 5'h04;
	localparam logic [4:0] ADDR_REF = 5'h07;
	// Gain/mux fields: [6:4] gain, [3] polarity, [2:0] channel
	localparam int GM_GAIN_LSB = 4;
	localparam int GM_POL_BIT = 3;
	localparam int GM_CHAN_LSB = 0;
	// Reference fields
	localparam int REF_ON_BIT = 0;
	localparam int REF_BUF_BIT = 1;
	// Command byte fields
	localparam int CMD_DIRECT_BIT = 7;
	localparam int CMD_READ_BIT = 6;
	localparam int CMD_WIDE_BIT = 5;
	// Edge counts within a frame
	localparam logic [4:0] CMD_LAST = 5'h07;
	localparam logic [4:0] DATA8_LAST = 5'h0f;
	localparam logic [4:0] DATA16_LAST = 5'h17;
	localparam int RESULT_PAD = 4;
	// Reset values
	localparam logic [6:0] GAIN_MUX_RST = 7'h00;
	localparam logic [1:0] REF_CTL_RST = 2'h0;
	// Oscillator timing
	localparam int CLK_FREQ_KHZ = 250000;
	localparam int OSC_FREQ_KHZ = 2500;
	localparam int OSC_HALF_CYCLES = CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ);
	localparam int OSC_CNT_W = 7;

	typedef enum logic [1:0] {ST_CMD, ST_WDATA, ST_RDATA, ST_DONE} sac_link_state_e;
endpackage

// ===== design/sac_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sac_sync #(
	parameter int WIDTH = 1
) (
	// Clock and clear
	input wire logic clk,
	input wire logic clear,
	// Level in and out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or posedge clear) begin
		if (clear) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // sac_sync
`default_nettype wire

// ===== testbench/sac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
	// Serial link
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// One frame, MSB first; rx takes dout just before each rising edge
	task automatic xfer(input int nbits, input logic [23:0] tx, output logic [23:0] rx,
		output logic oe9);
		rx = '0;
		oe9 = 1'b0;
		cs_n = 1'b0;
		#20;
		for (int k = 1; k <= nbits; k++) begin
			din = tx[nbits-k];
			#15;
			rx = {rx[22:0], dout};
			if (k == 9)
				oe9 = dout_oe;
			sclk = 1'b1;
			#15;
			sclk = 1'b0;
		end
		#15;
		cs_n = 1'b1;
		din = ~din;
		#45;
	endtask
endmodule // sac_host_model
`default_nettype wire

// ===== testbench/serial_adc_control_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_adc_control_port_tb import sac_pkg::*;;
	logic clk, reset, sclk, cs_n, din, dout, dout_oe, osc_en, cc_in, cc_out, cc_oe, cc_int;
	logic conv_valid, conv_start, ips, ref_en, rbe, oe;
	logic [11:0] conv_result;
	logic [2:0] ais, gsb;
	logic [23:0] r;
	int error_cnt = 0, checked = 0, starts = 0, cyc = 0, n;

	sac_host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));
	sac_adc_ctrl i_dut (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .dout_oe(dout_oe), .oscillator_enable_pin(osc_en),
		.conversion_clock_in(cc_in), .conversion_clock_out(cc_out),
		.conversion_clock_oe(cc_oe), .conv_clk_int(cc_int), .conv_valid(conv_valid),
		.conv_result(conv_result), .conv_start(conv_start), .analog_input_select(ais),
		.input_polarity_select(ips), .gain_select_bits(gsb), .ref_enable(ref_en),
		.reference_buffer_enable(rbe));

	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (conv_start === 1'b1)
			starts <= starts + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			close_out;
		end
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic settle;
		repeat (10) @(negedge clk);
	endtask
	task automatic wreg(input logic [4:0] a, input logic [7:0] d);
		i_host.xfer(16, {8'h00, 3'b000, a, d}, r, oe);
		settle;
	endtask
	task automatic rreg(input logic [4:0] a, input logic wide);
		if (wide)
			i_host.xfer(24, {3'b011, a, 16'h0000}, r, oe);
		else
			i_host.xfer(16, {8'h00, 3'b010, a, 8'h00}, r, oe);
	endtask
	task automatic osc_wait(input logic lvl);
		n = 0;
		while (cc_out !== lvl && n < 300) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic close_out;
		$display("Counts: checked %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		osc_en = 1'b0;
		cc_in = 1'b0;
		conv_valid = 1'b0;
		conv_result = 12'h000;
		repeat (4) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		settle;
		chk("reset outputs", 16'h0000, {ais, ips, gsb, ref_en, rbe});
		wreg(ADDR_REF, 8'h03);
		chk("ref bits", 16'h0003, {rbe, ref_en});
		i_host.xfer(24, {3'b001, 5'h06, 8'h01, 8'hff}, r, oe);
		settle;
		chk("wide write ref", 16'h0001, {rbe, ref_en});
		wreg(ADDR_REF, 8'h02);
		chk("ref bits", 16'h0002, {rbe, ref_en});
		i_host.xfer(12, {12'h000, 8'h07, 4'h0}, r, oe);
		settle;
		chk("ref after cut frame", 16'h0002, {rbe, ref_en});
		chk("dout_oe idle", 16'h0000, dout_oe);
		$display("Test reference done");
		for (int g = 0; g < 8; g++) begin
			wreg(ADDR_GAIN_MUX, {1'b0, g[2:0], g[0], ~g[2:0]});
			chk("gain mux", {g[2:0], g[0], ~g[2:0]}, {gsb, ips, ais});
			rreg(ADDR_GAIN_MUX, 1'b0);
			chk("reg4 read", {g[2:0], g[0], ~g[2:0]}, r[15:0]);
		end
		$display("Test gain mux done");
		@(negedge clk) conv_valid = 1'b1;
		conv_result = 12'ha53;
		@(negedge clk) conv_valid = 1'b0;
		wreg(5'h1f, 8'hff);
		rreg(ADDR_RES_LO, 1'b1);
		chk("result regs", 16'ha530, r[15:0]);
		chk("read oe", 16'h0001, oe);
		rreg(5'h1f, 1'b0);
		chk("unmapped read", 16'h0000, r[15:0]);
		$display("Test result read done");
		starts = 0;
		i_host.xfer(24, {8'haa, 16'h0000}, r, oe);
		settle;
		chk("direct readback", 16'ha530, r[15:0]);
		chk("direct oe", 16'h0001, oe);
		chk("conv starts", 16'h0001, starts[15:0]);
		chk("direct gain mux", 16'h002a, {gsb, ips, ais});
		$display("Test direct done");
		@(negedge clk) osc_en = 1'b1;
		settle;
		chk("clock oe on", 16'h0001, cc_oe);
		osc_wait(1'b0);
		osc_wait(1'b1);
		osc_wait(1'b0);
		chk("osc half period", 16'd50, n[15:0]);
		@(negedge clk) osc_en = 1'b0;
		for (int i = 0; i < 4; i++) begin
			cc_in = i[0];
			repeat (20) @(negedge clk);
			chk("external clock", {1'b0, i[0]}, {cc_oe, cc_int});
		end
		$display("Test oscillator done");
		close_out;
	end
endmodule // serial_adc_control_port_tb
`default_nettype wire
